// File: logic/olg_guard.v
// overtravel limit guard: limit inputs, direction blocking, stop sequence, alarm
// assumes settings are static and sampled once after reset (power-up)
`timescale 1ns/1ps
`include "olg_consts.vh"

module olg_guard #(
   parameter [`OLG_CNT_W-1:0] FILTER_CYCLES = `OLG_FILTER_CYC
) (
   // clock and reset
   input  wire                     sys_clk_in,
   input  wire                     arst_n_in,
   // limit switches, high = connected to common
   input  wire                     fwd_limit_in,
   input  wire                     rev_limit_in,
   // settings, sampled once after reset
   input  wire [`OLG_SEL_W-1:0]    overtravel_select_in,
   input  wire [`OLG_SEL_W-1:0]    overtravel_stop_mode_in,
   input  wire [`OLG_TRQ_W-1:0]    quick_stop_torque_in,
   // motor status
   input  wire                     motor_stopped_in,
   // direction control
   output reg                      fwd_block_out,
   output reg                      rev_block_out,
   output reg                      fwd_torque_zero_out,
   output reg                      rev_torque_zero_out,
   // stop sequence
   output reg                      decel_active_out,
   output reg                      dyn_brake_out,
   output reg                      quick_stop_out,
   output reg  [`OLG_TRQ_W-1:0]    torque_limit_out,
   output reg                      err_cnt_hold_out,
   output reg                      err_cnt_clear_out,
   // alarm
   output reg                      alarm_out,
   output reg  [7:0]               alarm_code_out
);

   wire [1:0]            lim_raw;
   wire [1:0]            lim_conn;
   wire                  fwd_conn;
   wire                  rev_conn;
   reg                   loaded_q;
   reg [`OLG_SEL_W-1:0]  sel_q;
   reg [`OLG_SEL_W-1:0]  mode_q;
   reg [`OLG_TRQ_W-1:0]  qtrq_q;
   reg [`OLG_ST_W-1:0]   state_q;
   reg [`OLG_ST_W-1:0]   state_d;
   reg                   fwd_open;
   reg                   rev_open;
   reg                   alarm_d;
   wire                  sel_block;
   wire                  mode_dbrake;
   wire                  mode_ztorque;
   wire                  mode_qstop;
   wire                  nxt_decel;
   wire                  nxt_stopped;
   wire                  nxt_idle;

   // ------------------------------------------------------------
   // input filtering
   // ------------------------------------------------------------
   assign lim_raw  = {rev_limit_in, fwd_limit_in};
   assign fwd_conn = lim_conn[0];
   assign rev_conn = lim_conn[1];

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_lim
         olg_filter #(
            .FILTER_CYCLES (FILTER_CYCLES)
         ) u_olg_filter (
            .sys_clk_in (sys_clk_in),
            .arst_n_in  (arst_n_in),
            .raw_in     (lim_raw[gi]),
            .level_out  (lim_conn[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // setting and state decode
   // ------------------------------------------------------------
   assign sel_block    = (sel_q == `OLG_SEL_BLOCK);
   assign mode_dbrake  = (mode_q == `OLG_MODE_DBRAKE);
   assign mode_ztorque = (mode_q == `OLG_MODE_ZTORQUE);
   assign mode_qstop   = (mode_q == `OLG_MODE_QSTOP);
   assign nxt_decel    = (state_d == `OLG_ST_DECEL);
   assign nxt_stopped  = (state_d == `OLG_ST_STOPPED);
   assign nxt_idle     = (state_d == `OLG_ST_IDLE);

   // ------------------------------------------------------------
   // settings capture
   // ------------------------------------------------------------
   // sample once per power cycle; out-of-range codes fall back to defaults
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         loaded_q <= 1'b0;
         sel_q    <= `OLG_SEL_RESET;
         mode_q   <= `OLG_MODE_RESET;
         qtrq_q   <= {`OLG_TRQ_W{1'b0}};
      end else if (!loaded_q) begin
         loaded_q <= 1'b1;
         sel_q    <= (overtravel_select_in > `OLG_SEL_ALARM) ? `OLG_SEL_RESET
                                                             : overtravel_select_in;
         mode_q   <= (overtravel_stop_mode_in > `OLG_MODE_QSTOP) ? `OLG_MODE_RESET
                                                                 : overtravel_stop_mode_in;
         qtrq_q   <= quick_stop_torque_in;
      end
   end

   // ------------------------------------------------------------
   // limit evaluation and alarm
   // ------------------------------------------------------------
   always @* begin
      // selection 1 masks both inputs; settings ignored until loaded
      fwd_open = loaded_q && (sel_q != `OLG_SEL_IGNORE) && !fwd_conn;
      rev_open = loaded_q && (sel_q != `OLG_SEL_IGNORE) && !rev_conn;
      alarm_d  = alarm_out;
      if (sel_q == `OLG_SEL_BLOCK && fwd_open && rev_open) begin
         alarm_d = 1'b1;
      end
      if (sel_q == `OLG_SEL_ALARM && (fwd_open || rev_open)) begin
         alarm_d = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // stop sequence state machine
   // ------------------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         `OLG_ST_IDLE: begin
            if (sel_q == `OLG_SEL_BLOCK && (fwd_open || rev_open)) begin
               state_d = motor_stopped_in ? `OLG_ST_STOPPED : `OLG_ST_DECEL;
            end
         end
         `OLG_ST_DECEL: begin
            if (!(fwd_open || rev_open)) begin
               state_d = `OLG_ST_IDLE;
            end else if (motor_stopped_in) begin
               state_d = `OLG_ST_STOPPED;
            end
         end
         `OLG_ST_STOPPED: begin
            if (!(fwd_open || rev_open)) begin
               state_d = `OLG_ST_IDLE;
            end
         end
         default: begin
            state_d = `OLG_ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // direction outputs
   // ------------------------------------------------------------
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         fwd_block_out       <= 1'b0;
         rev_block_out       <= 1'b0;
         fwd_torque_zero_out <= 1'b0;
         rev_torque_zero_out <= 1'b0;
      end else begin
         fwd_block_out       <= sel_block && fwd_open;
         rev_block_out       <= sel_block && rev_open;
         // zero torque toward the blocked side
         fwd_torque_zero_out <= sel_block && fwd_open && (nxt_stopped || mode_ztorque);
         rev_torque_zero_out <= sel_block && rev_open && (nxt_stopped || mode_ztorque);
      end
   end

   // ------------------------------------------------------------
   // stop sequence outputs
   // ------------------------------------------------------------
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q           <= `OLG_ST_IDLE;
         decel_active_out  <= 1'b0;
         dyn_brake_out     <= 1'b0;
         quick_stop_out    <= 1'b0;
         torque_limit_out  <= {`OLG_TRQ_W{1'b0}};
         err_cnt_hold_out  <= 1'b0;
         err_cnt_clear_out <= 1'b0;
      end else begin
         state_q           <= state_d;
         decel_active_out  <= nxt_decel;
         // per-mode braking and error counter handling
         dyn_brake_out     <= nxt_decel && mode_dbrake;
         quick_stop_out    <= nxt_decel && mode_qstop;
         err_cnt_hold_out  <= !nxt_idle && !mode_qstop;
         err_cnt_clear_out <= !nxt_idle && mode_qstop;
         torque_limit_out  <= (nxt_decel && mode_qstop) ? qtrq_q : {`OLG_TRQ_W{1'b0}};
      end
   end

   // ------------------------------------------------------------
   // alarm outputs
   // ------------------------------------------------------------
   // alarm is sticky until power cycle; the drive has no alarm reset here
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         alarm_out      <= 1'b0;
         alarm_code_out <= `OLG_ALARM_NONE;
      end else begin
         alarm_out      <= alarm_d;
         alarm_code_out <= alarm_d ? `OLG_ALARM_NUM : `OLG_ALARM_NONE;
      end
   end

endmodule // olg_guard

// File: logic/olg_consts.vh
// constants for the overtravel limit guard
// assumes inclusion by the guard, its input filter and its checker
`ifndef OLG_CONSTS_VH
`define OLG_CONSTS_VH

// ------------------------------------------------------------
// prohibition selection codes
// ------------------------------------------------------------
`define OLG_SEL_W          2
`define OLG_SEL_BLOCK      2'h0
`define OLG_SEL_IGNORE     2'h1
`define OLG_SEL_ALARM      2'h2
`define OLG_SEL_RESET      2'h1

// ------------------------------------------------------------
// stop mode codes
// ------------------------------------------------------------
`define OLG_MODE_DBRAKE    2'h0
`define OLG_MODE_ZTORQUE   2'h1
`define OLG_MODE_QSTOP     2'h2
`define OLG_MODE_RESET     2'h0

// ------------------------------------------------------------
// alarm and timing
// ------------------------------------------------------------
`define OLG_ALARM_NUM      8'h26
`define OLG_ALARM_NONE     8'h00
// 100 us of stable level at the 25 ns clock
`define OLG_FILTER_CYC     12'hFA0
`define OLG_CNT_W          12
`define OLG_TRQ_W          16

// ------------------------------------------------------------
// guard states
// ------------------------------------------------------------
`define OLG_ST_W           2
`define OLG_ST_IDLE        2'h0
`define OLG_ST_DECEL       2'h1
`define OLG_ST_STOPPED     2'h2

`endif

// File: logic/olg_filter.v
// synchroniser and stability filter for one limit-switch input
// assumes the raw input is asynchronous and may bounce
`timescale 1ns/1ps
`include "olg_consts.vh"

module olg_filter #(
   parameter [`OLG_CNT_W-1:0] FILTER_CYCLES = `OLG_FILTER_CYC
) (
   // clock and reset
   input  wire sys_clk_in,
   input  wire arst_n_in,
   // raw and filtered level
   input  wire raw_in,
   output reg  level_out
);

   reg                  sync1_q;
   reg                  sync2_q;
   reg [`OLG_CNT_W-1:0] cnt_q;

   // ------------------------------------------------------------
   // two-stage sync, then a level must stay put for FILTER_CYCLES
   // ------------------------------------------------------------
   // reset to "connected" so nothing blocks before the first sample settles
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sync1_q   <= 1'b1;
         sync2_q   <= 1'b1;
         cnt_q     <= {`OLG_CNT_W{1'b0}};
         level_out <= 1'b1;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         if (sync2_q == level_out) begin
            cnt_q <= {`OLG_CNT_W{1'b0}};
         end else if (cnt_q >= FILTER_CYCLES - 1'b1) begin
            cnt_q     <= {`OLG_CNT_W{1'b0}};
            level_out <= sync2_q;
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

endmodule // olg_filter

// File: tb/olg_switches.sv
// limit switch pair model: a closed contact reads 1, an open one 0
// assumes chatter is only commanded where the bench expects it filtered
`timescale 1ns/1ps
module olg_switches (
   // clock
   input  wire  sys_clk_in,
   // commands from the bench
   input  wire  fwd_open_in,
   input  wire  rev_open_in,
   input  wire  bounce_in,
   // contact levels
   output logic fwd_limit_out,
   output logic rev_limit_out
);
   logic chatter_q = 1'b0;
   always @(posedge sys_clk_in) begin
      chatter_q <= ~chatter_q;
   end
   assign fwd_limit_out = bounce_in ? chatter_q : ~fwd_open_in;
   assign rev_limit_out = bounce_in ? ~chatter_q : ~rev_open_in;
endmodule // olg_switches

// File: tb/olg_guard_chk.sv
// assertion checker for the overtravel guard
// assumes settings are captured at the first edge after reset release
`timescale 1ns/1ps
`include "olg_consts.vh"
module olg_guard_chk (
   // clock and reset
   input wire        sys_clk_in,
   input wire        arst_n_in,
   // settings and status
   input wire [1:0]  overtravel_select_in,
   input wire [1:0]  overtravel_stop_mode_in,
   input wire [15:0] quick_stop_torque_in,
   input wire        motor_stopped_in,
   // outputs watched
   input wire        fwd_block_out,
   input wire        rev_block_out,
   input wire        decel_active_out,
   input wire        dyn_brake_out,
   input wire        quick_stop_out,
   input wire [15:0] torque_limit_out,
   input wire        err_cnt_hold_out,
   input wire        err_cnt_clear_out,
   input wire        alarm_out,
   input wire [7:0]  alarm_code_out
);
   logic        arm_q;
   logic [1:0]  sel_q;
   logic [1:0]  mode_q;
   logic [15:0] trq_q;
   // own frozen copy, so late setting changes cannot mislead the checks
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         arm_q <= 1'b1;
      end else if (arm_q) begin
         arm_q  <= 1'b0;
         // out-of-range codes fall back to the reset defaults
         sel_q  <= (overtravel_select_in == 2'h3) ? 2'h1 : overtravel_select_in;
         mode_q <= (overtravel_stop_mode_in == 2'h3) ? 2'h0 : overtravel_stop_mode_in;
         trq_q  <= quick_stop_torque_in;
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_stopping;
      decel_active_out && motor_stopped_in;
   endsequence
   alarm_code_a : assert property (alarm_code_out == (alarm_out ? 8'h26 : 8'h00))
      else $error("alarm code mismatch");
   alarm_hold_a : assert property (alarm_out |=> alarm_out)
      else $error("alarm dropped");
   ignore_sel_a : assert property (!arm_q && sel_q == 2'h1 |->
         !(fwd_block_out || rev_block_out || alarm_out))
      else $error("ignored input acted");
   alarm_only_a : assert property (!arm_q && sel_q == 2'h2 |->
         !fwd_block_out && !rev_block_out && !decel_active_out)
      else $error("alarm mode blocked");
   dyn_brake_a : assert property (dyn_brake_out |->
         decel_active_out && mode_q == 2'h0 && err_cnt_hold_out)
      else $error("brake state wrong");
   quick_stop_a : assert property (quick_stop_out |->
         mode_q == 2'h2 && torque_limit_out == trq_q && err_cnt_clear_out)
      else $error("quick stop wrong");
   stop_end_a : assert property (s_stopping |=> !decel_active_out && !dyn_brake_out)
      else $error("decel did not end");
   decel_cause_a : assert property ($rose(decel_active_out) |->
         fwd_block_out || rev_block_out)
      else $error("decel without block");
endmodule // olg_guard_chk
bind olg_guard olg_guard_chk u_olg_guard_chk (.*);

// File: tb/overtravel_limit_guard_bench.sv
// self-checking bench for the overtravel guard with a switch model
// assumes a 40 MHz clock and a four-cycle input filter
`timescale 1ns/1ps
module overtravel_limit_guard_bench;
   logic        sys_clk_in = 1'b0;
   logic        arst_n_in = 1'b0;
   logic        motor_stopped_in = 1'b0;
   logic        fwd_open = 1'b0;
   logic        rev_open = 1'b0;
   logic        bounce = 1'b0;
   logic [1:0]  sel = 2'h0;
   logic [1:0]  mode = 2'h0;
   logic [15:0] trq = 16'h1A5C;
   wire         fwd_lim, rev_lim, fb, rb, ftz, rtz, dec, dbr, qs, hold, clr, alm;
   wire  [15:0] tl;
   wire  [7:0]  code;
   int          n_fail = 0;
   int          checks = 0;
   olg_switches u_olg_switches (.sys_clk_in(sys_clk_in), .fwd_open_in(fwd_open),
      .rev_open_in(rev_open), .bounce_in(bounce), .fwd_limit_out(fwd_lim),
      .rev_limit_out(rev_lim));
   olg_guard #(.FILTER_CYCLES(12'h004)) u_olg_guard (.sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in), .fwd_limit_in(fwd_lim), .rev_limit_in(rev_lim),
      .overtravel_select_in(sel), .overtravel_stop_mode_in(mode), .quick_stop_torque_in(trq),
      .motor_stopped_in(motor_stopped_in), .fwd_block_out(fb), .rev_block_out(rb),
      .fwd_torque_zero_out(ftz), .rev_torque_zero_out(rtz), .decel_active_out(dec),
      .dyn_brake_out(dbr), .quick_stop_out(qs), .torque_limit_out(tl), .err_cnt_hold_out(hold),
      .err_cnt_clear_out(clr), .alarm_out(alm), .alarm_code_out(code));
   task chk(string n, logic [15:0] e, logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // settings are changed after capture on purpose: they must not take effect
   task rst(logic [1:0] s, logic [1:0] m);
      @(posedge sys_clk_in);
      arst_n_in <= 1'b0;
      sel <= s;
      mode <= m;
      fwd_open <= 1'b0;
      rev_open <= 1'b0;
      motor_stopped_in <= 1'b0;
      repeat (8) @(posedge sys_clk_in);
      arst_n_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      sel <= s ^ 2'h1;
      mode <= m ^ 2'h1;
   endtask
   // filter plus pipeline is about seven cycles, twelve leaves margin
   task lim(logic f, logic r);
      @(posedge sys_clk_in);
      fwd_open <= f;
      rev_open <= r;
      repeat (12) @(posedge sys_clk_in);
      #1;
   endtask
   task t_block;
      rst(2'h0, 2'h0);
      lim(1'b1, 1'b0);
      chk("fb", 16'h1, {15'h0, fb});
      chk("rb", 16'h0, {15'h0, rb});
      chk("brake", 16'h3, {14'h0, dbr, hold});
      @(posedge sys_clk_in);
      motor_stopped_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      #1;
      chk("stop", 16'h1, {14'h0, dec, ftz});
      lim(1'b0, 1'b0);
      chk("fb", 16'h0, {15'h0, fb});
      lim(1'b0, 1'b1);
      chk("blocks", 16'h1, {14'h0, fb, rb});
   endtask
   task t_modes;
      for (int m = 1; m < 3; m++) begin
         rst(m[1:0], m[1:0]);
         rst(2'h0, m[1:0]);
         lim(1'b0, 1'b1);
         if (m == 1) chk("rtz", 16'h1, {15'h0, rtz});
         else chk("qstop", 16'h0001, {15'h0, qs & clr});
         if (m == 2) chk("tl", trq, tl);
      end
   endtask
   task t_bounce;
      rst(2'h0, 2'h0);
      bounce <= 1'b1;
      repeat (40) @(posedge sys_clk_in);
      #1;
      chk("chatter", 16'h0, {13'h0, fb, rb, alm});
      @(posedge sys_clk_in);
      #1;
      chk("chatter", 16'h0, {13'h0, fb, rb, alm});
      @(posedge sys_clk_in);
      bounce <= 1'b0;
   endtask
   task t_alarm;
      rst(2'h0, 2'h0);
      lim(1'b1, 1'b1);
      chk("code", 16'h0026, {8'h0, code});
      lim(1'b0, 1'b0);
      chk("alm", 16'h1, {15'h0, alm});
      rst(2'h2, 2'h0);
      lim(1'b0, 1'b1);
      chk("sel2", 16'h1, {14'h0, rb, alm});
      rst(2'h1, 2'h0);
      lim(1'b1, 1'b1);
      chk("sel1", 16'h0, {14'h0, fb, alm});
      rst(2'h3, 2'h0);
      lim(1'b1, 1'b1);
      chk("sel3", 16'h0, {14'h0, fb, alm});
      rst(2'h0, 2'h3);
      lim(1'b1, 1'b0);
      chk("mode3", 16'h3, {14'h0, dbr, hold});
   endtask
   task summarize;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      forever #12.5 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      repeat (3000) @(posedge sys_clk_in);
      n_fail++;
      summarize();
   end
   initial begin
      t_block();
      t_modes();
      t_bounce();
      t_alarm();
      summarize();
   end
endmodule // overtravel_limit_guard_bench
